// ===== include/isx_regs.svh
// Purpose: Opcode patterns, field positions and reset values for the instruction executor
// Assumes: 14-bit instruction words, 8-bit data path
// Notes: Operation list below
// Operation
// - Pattern 00 1111 d fffffff increments the addressed file register, skip if zero.
// - Destination bit 0 writes accumulator, 1 writes back the file register.
// - Zero increment result discards prefetched instruction; runs a no-op; no flags.
// - Pattern 00 0100 d fffffff ORs accumulator with file register, sets zero, one cycle.
// - Pattern 11 1000 kkkkkkkk ORs literal into accumulator and updates zero flag.
// - Pattern 11 00xx kkkkkkkk loads literal into accumulator, one cycle, no flags.
// - The two don't-care bits of the load-literal opcode are ignored by decode.
`ifndef ISX_REGS_SVH
`define ISX_REGS_SVH
`define ISX_OP_INC_SKIP 6'h0f
`define ISX_OP_OR_FILE 6'h04
`define ISX_OP_OR_LIT 6'h38
`define ISX_OP_LOAD_LIT 4'hc
`define ISX_DEST_BIT 7
`define ISX_ACC_RESET 8'h00
`define ISX_ZERO_RESET 1'b0
`endif

// ===== include/isx_pkg.sv
// Purpose: Types for the instruction executor
// Assumes: Nothing beyond the constants header
// Notes: Decoded operation classes
package isx_pkg;
   typedef enum logic [4:0] {
      ISX_NONE = 5'h01,
      ISX_INC_SKIP = 5'h02,
      ISX_OR_FILE = 5'h04,
      ISX_OR_LIT = 5'h08,
      ISX_LOAD_LIT = 5'h10
   } isx_op_e;
endpackage : isx_pkg

// ===== design/isx_decode.sv
// Purpose: Opcode decoder for four single-word instructions
// Assumes: Instruction word is stable while instr_valid is high
// Notes: Purely combinational
`timescale 1ns/1ps
`include "isx_regs.svh"
module isx_decode import isx_pkg::*; (
   input wire logic [13:0] instr,
   output isx_op_e op
);
   always_comb begin
      if (instr[13:8] == `ISX_OP_INC_SKIP) begin
         op = ISX_INC_SKIP;
      end else if (instr[13:8] == `ISX_OP_OR_FILE) begin
         op = ISX_OR_FILE;
      end else if (instr[13:8] == `ISX_OP_OR_LIT) begin
         op = ISX_OR_LIT;
      end else if (instr[13:10] == `ISX_OP_LOAD_LIT) begin
         // Bits 9:8 are not looked at
         op = ISX_LOAD_LIT;
      end else begin
         op = ISX_NONE;
      end
   end
endmodule : isx_decode

// ===== design/isx_exec.sv
// Purpose: Execute stage for increment-skip, OR with file, OR literal and load literal
// Assumes: File register read data arrives combinationally for file_addr
// Notes: One instruction per cycle; a skip flushes the prefetched word
`timescale 1ns/1ps
`include "isx_regs.svh"
module isx_exec import isx_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   input wire logic [7:0] file_rdata,
   output logic [6:0] file_addr,
   output logic file_we,
   output logic [7:0] file_wdata,
   output logic [7:0] acc,
   output logic zero_flag,
   output logic flush
);
   typedef struct packed {
      logic [7:0] acc;
      logic zero;
      logic flush;
      logic file_we;
      logic [6:0] file_addr;
      logic [7:0] file_wdata;
   } isx_state_s;

   isx_state_s state_reg;
   isx_state_s state_next;
   isx_op_e op;
   logic [7:0] result;
   logic dest_file;
   logic exec;

   isx_decode u_decode (
      .instr(instr),
      .op(op)
   );

   // A discarded word still arrives valid; it executes as a no-op
   assign exec = instr_valid && !state_reg.flush;
   assign dest_file = instr[`ISX_DEST_BIT];
   assign file_addr = instr[6:0];

   always_comb begin
      state_next = state_reg;
      state_next.file_we = 1'b0;
      state_next.flush = 1'b0;
      result = 8'h00;
      case (op)
         ISX_INC_SKIP: result = file_rdata + 8'h01;
         ISX_OR_FILE: result = state_reg.acc | file_rdata;
         ISX_OR_LIT: result = state_reg.acc | instr[7:0];
         ISX_LOAD_LIT: result = instr[7:0];
         default: result = 8'h00;
      endcase
      if (exec) begin
         case (op)
            ISX_INC_SKIP: begin
               // Status untouched; zero result kills the fetched word
               state_next.flush = (result == 8'h00);
               if (dest_file) begin
                  state_next.file_we = 1'b1;
                  state_next.file_addr = instr[6:0];
                  state_next.file_wdata = result;
               end else begin
                  state_next.acc = result;
               end
            end
            ISX_OR_FILE: begin
               state_next.zero = (result == 8'h00);
               if (dest_file) begin
                  state_next.file_we = 1'b1;
                  state_next.file_addr = instr[6:0];
                  state_next.file_wdata = result;
               end else begin
                  state_next.acc = result;
               end
            end
            ISX_OR_LIT: begin
               state_next.acc = result;
               state_next.zero = (result == 8'h00);
            end
            ISX_LOAD_LIT: begin
               state_next.acc = result;
            end
            default: begin
               state_next.acc = state_reg.acc;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '{acc: `ISX_ACC_RESET, zero: `ISX_ZERO_RESET, flush: 1'b0,
                        file_we: 1'b0, file_addr: 7'h00, file_wdata: 8'h00};
      end else begin
         state_reg <= state_next;
      end
   end

   assign acc = state_reg.acc;
   assign zero_flag = state_reg.zero;
   assign flush = state_reg.flush;
   assign file_we = state_reg.file_we;
   assign file_wdata = state_reg.file_wdata;

   // The write lands one cycle after its instruction, when file_addr already
   // shows the next word; the register file must take the address of the
   // previous cycle, which state_reg.file_addr keeps for the checks below.

   // Increment-skip and destination select
   a_inc_write_back: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_INC_SKIP && dest_file |=>
      file_we && file_wdata == $past(file_rdata) + 8'h01 &&
      state_reg.file_addr == $past(instr[6:0]) && $stable(acc))
      else $error("increment write-back wrong");

   a_inc_to_acc: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_INC_SKIP && !dest_file |=>
      acc == $past(file_rdata) + 8'h01 && !file_we)
      else $error("increment into accumulator wrong");

   a_dest_acc_sel: assert property (@(posedge clk) disable iff (!resetn)
      exec && (op == ISX_INC_SKIP || op == ISX_OR_FILE) && !dest_file |=>
      !file_we)
      else $error("file written with destination zero");

   a_file_we_cause: assert property (@(posedge clk) disable iff (!resetn)
      file_we |->
      $past(exec) && $past(dest_file) &&
      ($past(op) == ISX_INC_SKIP || $past(op) == ISX_OR_FILE))
      else $error("file written by an instruction without write-back");

   // Skip and discard of the prefetched word
   a_skip_flush: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_INC_SKIP && file_rdata == 8'hff |=>
      flush ##1 !flush)
      else $error("skip did not flush exactly one word");

   a_skip_only_zero: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_INC_SKIP && file_rdata != 8'hff |=>
      !flush)
      else $error("skip without a zero result");

   a_flush_cause: assert property (@(posedge clk) disable iff (!resetn)
      flush |->
      $past(exec) && $past(op) == ISX_INC_SKIP && $past(file_rdata) == 8'hff)
      else $error("flush without a zero increment");

   a_skip_no_flags: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_INC_SKIP |=>
      $stable(zero_flag))
      else $error("increment-skip changed zero flag");

   a_flushed_noop: assert property (@(posedge clk) disable iff (!resetn)
      flush |=>
      $stable(acc) && !file_we)
      else $error("discarded word had an effect");

   a_idle_no_effect: assert property (@(posedge clk) disable iff (!resetn)
      !exec |=>
      $stable(acc) && $stable(zero_flag) && !file_we && !flush)
      else $error("idle or discarded word had an effect");

   // OR with file register
   a_or_file_acc: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_OR_FILE && !dest_file |=>
      acc == ($past(acc) | $past(file_rdata)))
      else $error("OR with file result wrong");

   a_or_file_write: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_OR_FILE && dest_file |=>
      file_we && file_wdata == ($past(acc) | $past(file_rdata)) && $stable(acc))
      else $error("OR with file write-back wrong");

   // Literal instructions
   a_or_lit_acc: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_OR_LIT |=>
      acc == ($past(acc) | $past(instr[7:0])))
      else $error("OR literal result wrong");

   a_lit_no_write: assert property (@(posedge clk) disable iff (!resetn)
      exec && (op == ISX_OR_LIT || op == ISX_LOAD_LIT) |=>
      !file_we)
      else $error("literal instruction wrote a file register");

   a_load_lit: assert property (@(posedge clk) disable iff (!resetn)
      exec && instr[13:10] == `ISX_OP_LOAD_LIT |=>
      acc == $past(instr[7:0]) && $stable(zero_flag))
      else $error("load literal wrong");

   a_dc_ignored: assert property (@(posedge clk) disable iff (!resetn)
      instr[13:10] == `ISX_OP_LOAD_LIT |->
      op == ISX_LOAD_LIT)
      else $error("load literal decode depends on don't-care bits");

   // Zero flag
   a_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_OR_LIT |=>
      zero_flag == (acc == 8'h00))
      else $error("zero flag wrong");

   a_or_file_zero: assert property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_OR_FILE |=>
      zero_flag == (($past(acc) | $past(file_rdata)) == 8'h00))
      else $error("zero flag wrong after OR with file");

   a_zero_cause: assert property (@(posedge clk) disable iff (!resetn)
      $changed(zero_flag) |->
      $past(exec) && ($past(op) == ISX_OR_FILE || $past(op) == ISX_OR_LIT))
      else $error("zero flag changed by an instruction that keeps it");

   // Main scenarios
   c_skip: cover property (@(posedge clk) disable iff (!resetn) flush);
   c_or_file_w: cover property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_OR_FILE && instr[7]);
   c_load_dc: cover property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_LOAD_LIT && instr[9:8] != 2'b00);
   c_zero_set: cover property (@(posedge clk) disable iff (!resetn) $rose(zero_flag));
   c_skip_acc: cover property (@(posedge clk) disable iff (!resetn)
      exec && op == ISX_INC_SKIP && !dest_file && file_rdata == 8'hff);
endmodule : isx_exec

// ===== testbench/incr_skip_or_literal_exec_tb.sv
// Purpose: Self-checking bench for the instruction executor
// Assumes: Inputs change on the falling edge, results read one falling edge later
// Notes: The bench plays the register file by driving file_rdata itself
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module incr_skip_or_literal_exec_tb;
   import isx_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [7:0] file_rdata = 8'h00;
   logic [6:0] file_addr;
   logic [7:0] file_wdata, acc;
   logic file_we, zero_flag, flush;
   int fails = 0;
   int checks_done = 0;
   isx_exec u_isx_exec (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
      .instr(instr), .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
      .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag), .flush(flush));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      if (fails == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // One instruction per cycle; results are settled by the next falling edge
   task automatic step(input logic [13:0] i, input logic [7:0] r);
      instr_valid = 1'b1;
      instr = i;
      file_rdata = r;
      @(negedge clk);
   endtask : step
   task automatic t_reset();
      `CHK("acc", 8'h00, acc)
      `CHK("zero", 1'b0, zero_flag)
      `CHK("flush", 1'b0, flush)
      `CHK("we", 1'b0, file_we)
      `CHK("wdata", 8'h00, file_wdata)
   endtask : t_reset
   task automatic t_load();
      step(14'h335a, 8'h00);
      `CHK("acc", 8'h5a, acc)
      step(14'h3000, 8'h00);
      `CHK("acc", 8'h00, acc)
      `CHK("zero", 1'b0, zero_flag)
   endtask : t_load
   task automatic t_or_lit();
      step(14'h309a, 8'h00);
      step(14'h3835, 8'h00);
      `CHK("acc", 8'hbf, acc)
      `CHK("zero", 1'b0, zero_flag)
      step(14'h3000, 8'h00);
      step(14'h3800, 8'h00);
      `CHK("zero", 1'b1, zero_flag)
      // A set flag exposes a load that wrongly clears it
      step(14'h30ff, 8'h00);
      `CHK("zero", 1'b1, zero_flag)
   endtask : t_or_lit
   task automatic t_or_file();
      step(14'h3091, 8'h00);
      instr = 14'h0455;
      #1;
      `CHK("addr", 7'h55, file_addr)
      step(14'h0455, 8'h13);
      `CHK("acc", 8'h93, acc)
      `CHK("zero", 1'b0, zero_flag)
      `CHK("we", 1'b0, file_we)
      step(14'h04d5, 8'h04);
      `CHK("we", 1'b1, file_we)
      `CHK("wdata", 8'h97, file_wdata)
      `CHK("acc", 8'h93, acc)
   endtask : t_or_file
   task automatic t_skip();
      step(14'h3011, 8'h00);
      step(14'h0fa0, 8'hff);
      `CHK("we", 1'b1, file_we)
      `CHK("wdata", 8'h00, file_wdata)
      `CHK("flush", 1'b1, flush)
      `CHK("acc", 8'h11, acc)
      `CHK("zero", 1'b0, zero_flag)
      // The prefetched load must be dropped
      step(14'h3077, 8'h00);
      `CHK("acc", 8'h11, acc)
      `CHK("flush", 1'b0, flush)
      step(14'h0f20, 8'h41);
      `CHK("acc", 8'h42, acc)
      `CHK("flush", 1'b0, flush)
      `CHK("we", 1'b0, file_we)
   endtask : t_skip
   task automatic t_edge();
      // OR with file giving zero sets the flag
      step(14'h3000, 8'h00);
      step(14'h0455, 8'h00);
      `CHK("zero", 1'b1, zero_flag)
      `CHK("acc", 8'h00, acc)
      // Skip into the accumulator while the flag is set
      step(14'h303c, 8'h00);
      step(14'h0f20, 8'hff);
      `CHK("acc", 8'h00, acc)
      `CHK("flush", 1'b1, flush)
      `CHK("zero", 1'b1, zero_flag)
      `CHK("we", 1'b0, file_we)
      // The discarded OR literal would change both acc and flag
      step(14'h38f0, 8'h00);
      `CHK("acc", 8'h00, acc)
      `CHK("zero", 1'b1, zero_flag)
      // A neighbouring pattern must not act as increment-skip
      step(14'h0ba0, 8'hff);
      `CHK("flush", 1'b0, flush)
      `CHK("we", 1'b0, file_we)
      `CHK("acc", 8'h00, acc)
      // A word that is not presented must not execute
      instr_valid = 1'b0;
      instr = 14'h38f0;
      @(negedge clk);
      `CHK("acc", 8'h00, acc)
      `CHK("zero", 1'b1, zero_flag)
   endtask : t_edge
   initial begin
      repeat (6) @(negedge clk);
      t_reset();
      resetn = 1'b1;
      t_load();
      t_or_lit();
      t_or_file();
      t_skip();
      t_edge();
      stop_test();
   end
   initial begin
      #5000;
      fails++;
      stop_test();
   end
endmodule : incr_skip_or_literal_exec_tb
